// [verilog/aimc_top.v]
/*
 Analog input mux control: special function registers for pair
 configuration, channel select, port 3 pin select, converter control and
 configuration; drives mux, gain, power and result formatting.
 Assumes the core's register port: single-cycle writes and reads,
 address valid with the strobe, inputs synchronous to i_clk.
*/
// Summary of operation
// - Converter, track-and-hold and gain amp powered only while enable bit is 1.
// - Nine-channel mux feeding a 12-bit converter, up to 100 ksps.
// - Reset clears all pair configuration bits: every pair single-ended.
// - Pair mode may change any time; next conversions use it.
// - Three-bit gain field selects gains 0.5, 1, 2, 4, 8 or 16.
// - Gain setting resets to unity.
// - Any set of port 3 pins may be enabled, one bit each.
// - Enabled even pins join one input, odd pins another, wired-OR.
// - High-voltage amplifier output chosen by channel select like any channel.
// - Pair configuration upper four bits read zero, writes ignored.
// - Bit 3 set makes port 3 even positive, odd negative pair.
// - Bit 2 set gives two's complement high-voltage amplifier result.
// - Bit 1 set pairs input two positive, input three negative.
// - Bit 0 set pairs input zero positive, input one negative.
// - Differential channels give two's complement words, single-ended straight.
// - Four-bit channel select; top bit set selects temperature sensor.
// - Port 3 pin n connects to mux exactly when its select bit is 1.
`timescale 1ns/1ns
`include "aimc_defines.vh"

module aimc_top #(
  parameter RES_W = 12,
  parameter PORT_W = 8
) (
  // Clock and reset
  input wire i_clk,
  input wire i_sys_rst,
  // Register port from the core
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  output reg [7:0] o_sfr_rdata,
  // Conversion data from the analog converter
  input wire i_conv_done,
  input wire [RES_W-1:0] i_conv_raw,
  // Analog front end control
  output reg o_pwr_en,
  output reg [`AIMC_SRC_W-1:0] o_mux_pos,
  output reg [`AIMC_SRC_W-1:0] o_mux_neg,
  output reg o_diff_mode,
  output reg [`AIMC_GAIN_W-1:0] o_gain_sel,
  output reg [PORT_W-1:0] o_p3_connect,
  output reg o_p3_even_sel,
  output reg o_p3_odd_sel,
  // Formatted result
  output reg [RES_W-1:0] o_data_word,
  output reg o_data_valid
);

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg [3:0] pair_cfg_reg;
  reg [3:0] chan_sel_reg;
  reg [PORT_W-1:0] port_sel_reg;
  reg [7:0] conv_cfg_reg;
  reg [7:0] conv_ctl_reg;

  // Reset images; only the stored low nibble of each is kept
  localparam [7:0] PAIR_CFG_RST = `AIMC_RST_PAIR_CFG;
  localparam [7:0] CHAN_SEL_RST = `AIMC_RST_CHAN_SEL;

  // Returns 1 when any bit at the given parity is set
  function parity_any;
    input [PORT_W-1:0] bits;
    input odd;
    integer k;
    begin
      parity_any = 1'b0;
      for (k = 0; k < PORT_W; k = k + 1) begin
        if ((k % 2) == odd) begin
          parity_any = parity_any | bits[k];
        end
      end
    end
  endfunction

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      pair_cfg_reg <= PAIR_CFG_RST[3:0];
      chan_sel_reg <= CHAN_SEL_RST[3:0];
      port_sel_reg <= {PORT_W{1'b0}};
      conv_cfg_reg <= `AIMC_RST_CONV_CFG;
      conv_ctl_reg <= `AIMC_RST_CONV_CTL;
    end else if (i_sfr_wr) begin
      case (i_sfr_addr)
        `AIMC_ADDR_PAIR_CFG: begin
          // Only the low nibble is stored; takes effect on next conversion
          pair_cfg_reg <= i_sfr_wdata[3:0];
        end
        `AIMC_ADDR_CHAN_SEL: begin
          chan_sel_reg <= i_sfr_wdata[3:0];
        end
        `AIMC_ADDR_PORT_SEL: begin
          port_sel_reg <= i_sfr_wdata[PORT_W-1:0];
        end
        `AIMC_ADDR_CONV_CFG: begin
          conv_cfg_reg <= i_sfr_wdata;
        end
        `AIMC_ADDR_CONV_CTL: begin
          conv_ctl_reg <= i_sfr_wdata;
        end
        default: begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read port

  reg [7:0] rdata_next;

  always @* begin
    rdata_next = 8'h00;
    case (i_sfr_addr)
      `AIMC_ADDR_PAIR_CFG: rdata_next = {4'h0, pair_cfg_reg};
      `AIMC_ADDR_CHAN_SEL: rdata_next = {4'h0, chan_sel_reg};
      `AIMC_ADDR_PORT_SEL: rdata_next = port_sel_reg;
      `AIMC_ADDR_CONV_CFG: rdata_next = conv_cfg_reg;
      `AIMC_ADDR_CONV_CTL: rdata_next = conv_ctl_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_sfr_rdata <= 8'h00;
    end else if (i_sfr_rd) begin
      o_sfr_rdata <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Mux decode and gain

  wire [3:0] pos_src;
  wire [3:0] neg_src;
  wire diff_now;
  reg [`AIMC_GAIN_W-1:0] gain_next;

  aimc_mux_decode aimc_mux_decode_i (
    .i_chan_sel(chan_sel_reg),
    .i_pair_cfg(pair_cfg_reg),
    .o_pos_src(pos_src),
    .o_neg_src(neg_src),
    .o_diff(diff_now)
  );

  // Undefined gain codes fall back to unity rather than an odd gain
  always @* begin
    case (conv_cfg_reg[`AIMC_GAIN_LSB +: `AIMC_GAIN_W])
      `AIMC_GAIN_X2: gain_next = `AIMC_GAIN_X2;
      `AIMC_GAIN_X4: gain_next = `AIMC_GAIN_X4;
      `AIMC_GAIN_X8: gain_next = `AIMC_GAIN_X8;
      `AIMC_GAIN_X16: gain_next = `AIMC_GAIN_X16;
      `AIMC_GAIN_XHALF: gain_next = `AIMC_GAIN_XHALF;
      default: gain_next = `AIMC_GAIN_X1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Front end outputs

  wire enabled;
  assign enabled = conv_ctl_reg[`AIMC_BIT_ENABLE];

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pwr_en <= 1'b0;
      o_mux_pos <= `AIMC_SRC_NONE;
      o_mux_neg <= `AIMC_SRC_NONE;
      o_diff_mode <= 1'b0;
      o_gain_sel <= `AIMC_GAIN_X1;
      o_p3_connect <= {PORT_W{1'b0}};
      o_p3_even_sel <= 1'b0;
      o_p3_odd_sel <= 1'b0;
    end else begin
      // Shutdown parks the mux so no source loads the track-and-hold
      o_pwr_en <= enabled;
      o_mux_pos <= enabled ? pos_src : `AIMC_SRC_NONE;
      o_mux_neg <= enabled ? neg_src : `AIMC_SRC_NONE;
      o_diff_mode <= diff_now;
      o_gain_sel <= gain_next;
      o_p3_connect <= port_sel_reg;
      o_p3_even_sel <= parity_any(port_sel_reg, 1'b0);
      o_p3_odd_sel <= parity_any(port_sel_reg, 1'b1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result formatting

  wire [RES_W-1:0] fmt_word;

  aimc_result_fmt #(
    .WIDTH(RES_W)
  ) aimc_result_fmt_i (
    .i_raw(i_conv_raw),
    .i_diff(o_diff_mode),
    .o_word(fmt_word)
  );

  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_data_word <= {RES_W{1'b0}};
      o_data_valid <= 1'b0;
    end else begin
      o_data_valid <= i_conv_done & enabled;
      if (i_conv_done & enabled) begin
        o_data_word <= fmt_word;
      end
    end
  end

endmodule

// [verilog/aimc_defines.vh]
/*
 Constants for the analog input mux control block: register addresses,
 field positions, reset values and mux codes.
 Assumes inclusion by bare name from the design files.
*/
`ifndef AIMC_DEFINES_VH
`define AIMC_DEFINES_VH

// Register addresses on the core's special function register port
`define AIMC_ADDR_PAIR_CFG 8'hBA
`define AIMC_ADDR_CHAN_SEL 8'hBB
`define AIMC_ADDR_PORT_SEL 8'hBD
`define AIMC_ADDR_CONV_CFG 8'hBC
`define AIMC_ADDR_CONV_CTL 8'hE8

// Reset values
`define AIMC_RST_PAIR_CFG 8'h00
`define AIMC_RST_CHAN_SEL 8'h00
`define AIMC_RST_PORT_SEL 8'h00
`define AIMC_RST_CONV_CFG 8'hF8
`define AIMC_RST_CONV_CTL 8'h00

// Writable masks
`define AIMC_MASK_LOW4 8'h0F

// Pair configuration bit positions
`define AIMC_BIT_AIN01 0
`define AIMC_BIT_AIN23 1
`define AIMC_BIT_HVSGN 2
`define AIMC_BIT_PORT3 3

// Converter control enable bit position
`define AIMC_BIT_ENABLE 7

// Gain select field
`define AIMC_GAIN_LSB 0
`define AIMC_GAIN_W 3
`define AIMC_GAIN_X1 3'h0
`define AIMC_GAIN_X2 3'h1
`define AIMC_GAIN_X4 3'h2
`define AIMC_GAIN_X8 3'h3
`define AIMC_GAIN_X16 3'h4
`define AIMC_GAIN_XHALF 3'h6

// Channel select codes
`define AIMC_CH_AIN0 4'h0
`define AIMC_CH_AIN1 4'h1
`define AIMC_CH_AIN2 4'h2
`define AIMC_CH_AIN3 4'h3
`define AIMC_CH_HVAMP 4'h4
`define AIMC_CH_GND 4'h5
`define AIMC_CH_P3EVEN 4'h6
`define AIMC_CH_P3ODD 4'h7

// Mux source codes driven to the analog front end
`define AIMC_SRC_W 4
`define AIMC_SRC_AIN0 4'h0
`define AIMC_SRC_AIN1 4'h1
`define AIMC_SRC_AIN2 4'h2
`define AIMC_SRC_AIN3 4'h3
`define AIMC_SRC_HVAMP 4'h4
`define AIMC_SRC_GND 4'h5
`define AIMC_SRC_P3EVEN 4'h6
`define AIMC_SRC_P3ODD 4'h7
`define AIMC_SRC_HVREF 4'h8
`define AIMC_SRC_TEMP 4'h9
`define AIMC_SRC_NONE 4'hF

`endif

// [verilog/aimc_mux_decode.v]
/*
 Combinational decode of channel select and pair configuration into the
 positive and negative mux sources and the differential flag.
 Assumes registered inputs from the control block.
*/
`timescale 1ns/1ns
`include "aimc_defines.vh"

module aimc_mux_decode (
  // Configuration
  input wire [3:0] i_chan_sel,
  input wire [3:0] i_pair_cfg,
  // Decoded routing
  output reg [3:0] o_pos_src,
  output reg [3:0] o_neg_src,
  output reg o_diff
);

  always @* begin
    o_pos_src = `AIMC_SRC_TEMP;
    o_neg_src = `AIMC_SRC_GND;
    o_diff = 1'b0;
    if (i_chan_sel[3]) begin
      o_pos_src = `AIMC_SRC_TEMP;
    end else begin
      case (i_chan_sel)
        `AIMC_CH_AIN0, `AIMC_CH_AIN1: begin
          if (i_pair_cfg[`AIMC_BIT_AIN01]) begin
            o_pos_src = `AIMC_SRC_AIN0;
            o_neg_src = `AIMC_SRC_AIN1;
            o_diff = 1'b1;
          end else begin
            o_pos_src = i_chan_sel;
          end
        end
        `AIMC_CH_AIN2, `AIMC_CH_AIN3: begin
          if (i_pair_cfg[`AIMC_BIT_AIN23]) begin
            o_pos_src = `AIMC_SRC_AIN2;
            o_neg_src = `AIMC_SRC_AIN3;
            o_diff = 1'b1;
          end else begin
            o_pos_src = i_chan_sel;
          end
        end
        `AIMC_CH_HVAMP, `AIMC_CH_GND: begin
          if (i_pair_cfg[`AIMC_BIT_HVSGN]) begin
            o_pos_src = `AIMC_SRC_HVAMP;
            o_neg_src = `AIMC_SRC_HVREF;
            o_diff = 1'b1;
          end else begin
            o_pos_src = i_chan_sel;
          end
        end
        default: begin
          if (i_pair_cfg[`AIMC_BIT_PORT3]) begin
            o_pos_src = `AIMC_SRC_P3EVEN;
            o_neg_src = `AIMC_SRC_P3ODD;
            o_diff = 1'b1;
          end else begin
            o_pos_src = i_chan_sel;
          end
        end
      endcase
    end
  end

endmodule

// [verilog/aimc_result_fmt.v]
/*
 Result formatter: turns a raw converter code into the data word,
 straight for single-ended and two's complement for differential.
 Assumes the raw code is offset binary with midscale at zero difference.
*/
`timescale 1ns/1ns

module aimc_result_fmt #(
  parameter WIDTH = 12
) (
  // Raw code and mode
  input wire [WIDTH-1:0] i_raw,
  input wire i_diff,
  // Formatted word
  output wire [WIDTH-1:0] o_word
);

  // Flipping the top bit maps offset binary onto two's complement
  assign o_word = i_diff ? {~i_raw[WIDTH-1], i_raw[WIDTH-2:0]} : i_raw;

endmodule

// [dv/aimc_chk.sv]
/* Port checker for aimc_top.
   Assumes it is bound into aimc_top. */
`timescale 1ns/1ns
module aimc_chk #(
  parameter RES_W = 12,
  parameter PORT_W = 8
) (
  // Clock and register port
  input wire i_clk,
  input wire i_sys_rst,
  input wire [7:0] i_sfr_addr,
  input wire i_sfr_wr,
  input wire i_sfr_rd,
  input wire [7:0] i_sfr_wdata,
  input wire [7:0] o_sfr_rdata,
  // Converter and front end
  input wire i_conv_done,
  input wire [RES_W-1:0] i_conv_raw,
  input wire o_pwr_en,
  input wire [3:0] o_mux_pos,
  input wire [3:0] o_mux_neg,
  input wire o_diff_mode,
  input wire [PORT_W-1:0] o_p3_connect,
  input wire o_p3_even_sel,
  input wire o_p3_odd_sel,
  input wire [RES_W-1:0] o_data_word,
  input wire o_data_valid
);
  wire wr_ctl = i_sfr_wr && i_sfr_addr == 8'hE8;
  wire wr_prt = i_sfr_wr && i_sfr_addr == 8'hBD;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////
  a_pwr_follow:
    assert property (wr_ctl ##1 !wr_ctl |=> o_pwr_en == $past(i_sfr_wdata[7], 2))
    else $error("power enable wrong");
  // Guard skips the cycle where power and register disagree
  a_valid_en:
    assert property (i_conv_done && !$past(wr_ctl) |=> o_data_valid == $past(o_pwr_en))
    else $error("data valid wrong");
  a_word_fmt:
    assert property (o_data_valid |-> o_data_word ==
      ($past(i_conv_raw) ^ {$past(o_diff_mode), {RES_W-1{1'b0}}}))
    else $error("data word wrong");
  a_pair_hi_zero:
    assert property (i_sfr_rd && i_sfr_addr == 8'hBA |=> o_sfr_rdata[7:4] == 4'h0)
    else $error("pair upper bits not zero");
  a_p3_follow:
    assert property (wr_prt ##1 !wr_prt |=> o_p3_connect == $past(i_sfr_wdata, 2))
    else $error("port pin connect wrong");
  a_p3_parity:
    assert property (o_p3_even_sel == |(o_p3_connect & {PORT_W/2{2'b01}})
      && o_p3_odd_sel == |(o_p3_connect & {PORT_W/2{2'b10}}))
    else $error("parity select wrong");
  a_off_park:
    assert property (!o_pwr_en |-> o_mux_pos == 4'hF && o_mux_neg == 4'hF)
    else $error("mux not parked");
  a_hv_pair:
    assert property (o_pwr_en && o_mux_pos == 4'h4 |-> o_diff_mode == (o_mux_neg == 4'h8))
    else $error("hv pair wrong");
  c_diff_conv: cover property (o_data_valid && o_diff_mode);
  c_both_par: cover property (o_p3_even_sel && o_p3_odd_sel);
  c_hv_ref: cover property (o_mux_neg == 4'h8);
endmodule
bind aimc_top aimc_chk #(.RES_W(RES_W), .PORT_W(PORT_W)) aimc_chk_i (.*);

// [dv/aimc_adc_model.sv]
/* Converter stand-in: one done pulse a set latency after go.
   Assumes go is a one-cycle pulse on i_clk. */
`timescale 1ns/1ns
module aimc_adc_model (
  // Control
  input wire i_clk,
  input wire i_go,
  input wire [11:0] i_code,
  input wire [3:0] i_lat,
  // To the block
  output reg o_done = 1'b0,
  output reg [11:0] o_raw = 12'h5A5
);
  reg [4:0] cnt_reg = 5'h00;
  ////////////////////////////////////////
  always @(posedge i_clk) begin
    o_done <= 1'b0;
    // Stale code never held outside done
    o_raw <= ~o_raw;
    if (i_go)
      cnt_reg <= {1'b0, i_lat} + 5'h01;
    else if (cnt_reg != 5'h00)
      cnt_reg <= cnt_reg - 5'h01;
    if (cnt_reg == 5'h01 && !i_go) begin
      o_done <= 1'b1;
      o_raw <= i_code;
    end
  end
endmodule

// [dv/aimc_top_test.sv]
/* Self-checking bench for aimc_top.
   Assumes the converter model on the far side. */
`timescale 1ns/1ns
module aimc_top_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic go = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [11:0] code = 12'h000;
  logic [3:0] lat = 4'h0;
  logic done, dv, pwr, diff, evn, odd;
  logic [11:0] raw, word;
  logic [7:0] rdata, p3;
  logic [3:0] pos, neg;
  logic [2:0] gain;
  int failures = 0;
  int cmp_count = 0;
  // Row: pair cfg, channel, pos, neg, diff
  logic [19:0] rows [15] = '{20'h00050, 20'h10011, 20'h11011, 20'h22231,
    20'h23231, 20'h04450, 20'h44481, 20'h45481, 20'h86671, 20'h87671,
    20'h07750, 20'h05550, 20'h08950, 20'hFF950, 20'hB3231};
  logic [7:0] pv [3] = '{8'h05, 8'h82, 8'hFF};
  aimc_top aimc_top_i (.i_clk(clk), .i_sys_rst(rst), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata),
    .i_conv_done(done), .i_conv_raw(raw), .o_pwr_en(pwr), .o_mux_pos(pos),
    .o_mux_neg(neg), .o_diff_mode(diff), .o_gain_sel(gain), .o_p3_connect(p3),
    .o_p3_even_sel(evn), .o_p3_odd_sel(odd), .o_data_word(word), .o_data_valid(dv));
  aimc_adc_model aimc_adc_model_i (.i_clk(clk), .i_go(go), .i_code(code),
    .i_lat(lat), .o_done(done), .o_raw(raw));
  ////////////////////////////////////////
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("rdata", {4'h0, exp}, {4'h0, rdata});
  endtask
  // Latency alternates 0 and 7: prompt and slow converter
  task automatic conv(input logic [11:0] c, input logic ev, input logic [11:0] ew);
    int n;
    @(posedge clk);
    code <= c;
    go <= 1'b1;
    lat <= lat ^ 4'h7;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    // Look only at settled values, never in the launching edge's step
    do begin
      @(negedge clk);
      n++;
    end while (dv !== 1'b1 && n < 12);
    chk("valid", {11'h0, ev}, {11'h0, dv});
    if (ev)
      chk("word", ew, word);
  endtask
  task automatic complete_run;
    if (failures == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial forever #2 clk = ~clk;
  initial begin
    #100000;
    failures++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    wreg(8'hE8, 8'h80);
    chk("pwr", 12'h1, {11'h0, pwr});
    for (int i = 0; i < 15; i++) begin
      wreg(8'hBA, {4'h0, rows[i][19:16]});
      wreg(8'hBB, {4'h0, rows[i][15:12]});
      chk("pos", {8'h0, rows[i][11:8]}, {8'h0, pos});
      chk("neg", {8'h0, rows[i][7:4]}, {8'h0, neg});
      chk("diff", {8'h0, rows[i][3:0]}, {11'h0, diff});
      conv({8'h8A, 4'(i)}, 1'b1, {rows[i][0] ^ 1'b1, 7'h0A, 4'(i)});
    end
    wreg(8'hBA, 8'hFF);
    rreg(8'hBA, 8'h0F);
    rreg(8'h55, 8'h00);
    for (int k = 0; k < 3; k++) begin
      wreg(8'hBD, pv[k]);
      rreg(8'hBD, pv[k]);
      chk("p3", {4'h0, pv[k]}, {4'h0, p3});
      chk("sel", {10'h0, 2'(k + 1)}, {10'h0, odd, evn});
    end
    for (int g = 0; g < 8; g++) begin
      wreg(8'hBC, {5'h1F, 3'(g)});
      chk("gain", (g == 5 || g == 7) ? 12'h0 : 12'(g), {9'h0, gain});
    end
    wreg(8'hE8, 8'h00);
    chk("pos", 12'hF, {8'h0, pos});
    conv(12'h456, 1'b0, 12'h000);
    // Dirty state before a mid-run reset: odd gain, power on, pins set
    wreg(8'hBC, 8'h06);
    chk("gain", 12'h6, {9'h0, gain});
    wreg(8'hE8, 8'h80);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("pwr", 12'h0, {11'h0, pwr});
    chk("gain", 12'h0, {9'h0, gain});
    rreg(8'hBA, 8'h00);
    rreg(8'hBC, 8'hF8);
    rreg(8'hBD, 8'h00);
    chk("p3", 12'h0, {4'h0, p3});
    conv(12'h123, 1'b0, 12'h000);
    complete_run();
  end
endmodule
